// ==== design/mpe_port.sv ====
// port data path joining a switch fabric port to MII/RMII pins or an internal PHY
// assumes link clocks are asynchronous pins, sampled here; mode held stable while running
// Function
// (R1) heartbeat on collision pin only at 10M half duplex after external transmit
// (R2) heartbeat starts 0.6-1.6us after transmit enable drops, lasts 0.5-1.5us
// (R3) heartbeat disable bit suppresses the heartbeat
// (R4) external collision test signals collision for each external transmission
// (R5) switch collision test asserts internal collision per switch transmit, ignoring isolate
// (R6) external loopback returns external data to pins, hides it from switch
// (R7) in external loopback collision pin only driven with external collision test
// (R8) no heartbeat in external loopback; allowed during switch loopback
// (R9) external loopback carrier pin follows only external transmit enable
// (R10) switch loopback loops switch data internally, ignores external, ignores isolate
// (R11) switch loopback collision only with switch test; carrier from switch enable
// (R12) RMII uses only 2-bit data pairs with valids and the reference clock
// (R13) isolate in PHY modes floats data outputs and ignores data inputs
// (R14) RMII clock direction low takes pin clock, high drives internal 50MHz out
// (R15) RMII never makes heartbeat; disable bit has no effect
// (R16) RMII ignores external collision test; switch test and loopbacks remain
// (R17) RMII switch loopback asserts internal collision with switch test bit
// (R18) internal mode connects fabric MAC to the internal PHY directly
// (R19) MAC mode routes fabric to 4-bit pins and inputs from the pins
// (R20) MII PHY mode drives both clocks, carrier and collision pins
// (R21) turbo raises 100 to 200M; with turbo, speed bit picks 10 or 200
// (R22) port mode from stable input; tests only apply in PHY modes
`include "mpe_defs.svh"
module mpe_port (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration
    input wire logic [3:0] port_mode,
    input wire logic isolate_bit,
    input wire logic external_loopback_bit,
    input wire logic switch_loopback_bit,
    input wire logic external_collision_test_bit,
    input wire logic switch_collision_test_bit,
    input wire logic pulse_disable_bit,
    input wire logic turbo_enable,
    input wire logic speed_sel_lsb,
    input wire logic full_duplex,
    input wire logic rmii_clock_out,
    // switch fabric port
    input wire logic [3:0] sw_tx_data,
    input wire logic sw_tx_en,
    output logic [3:0] sw_rx_data,
    output logic sw_rx_dv,
    output logic sw_rx_er,
    output logic sw_col,
    output logic sw_crs,
    output logic sw_tx_strobe,
    input wire logic sw_rx_ready,
    // internal phy
    output logic [3:0] iphy_tx_data,
    output logic iphy_tx_en,
    input wire logic [3:0] iphy_rx_data,
    input wire logic iphy_rx_dv,
    input wire logic iphy_rx_er,
    input wire logic iphy_col,
    input wire logic iphy_crs,
    // external pins
    output logic [3:0] port1_tx_data_pins,
    output logic [3:0] port1_tx_data_oe,
    output logic port1_tx_valid_pin,
    output logic port1_tx_valid_oe,
    input wire logic [3:0] port1_rx_data_pins,
    input wire logic port1_rx_valid_pin,
    input wire logic port1_rx_error_pin,
    input wire logic port1_collision_in,
    output logic port1_collision_out,
    output logic port1_collision_oe,
    input wire logic port1_carrier_in,
    output logic port1_carrier_out,
    output logic port1_carrier_oe,
    input wire logic port1_tx_clock_in,
    output logic port1_tx_clock_out,
    output logic port1_tx_clock_oe,
    input wire logic port1_rx_clock_in,
    output logic port1_rx_clock_out,
    output logic port1_rx_clock_oe,
    // status
    output logic heartbeat_active
);
    // pin synchronisers
    logic [10:0] pin_s1_r;
    logic [10:0] pin_s2_r;
    logic [10:0] pin_d_r;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_s1_r <= 11'h000;
            pin_s2_r <= 11'h000;
            pin_d_r <= 11'h000;
        end
        else
        begin
            pin_s1_r <= {port1_rx_clock_in, port1_tx_clock_in, port1_carrier_in, port1_collision_in,
                         port1_rx_error_pin, port1_rx_valid_pin, port1_rx_data_pins, 1'b0};
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
        end
    end
    wire [3:0] p_rxd = pin_s2_r[4:1];
    wire p_rxdv = pin_s2_r[5];
    wire p_rxer = pin_s2_r[6];
    wire p_col = pin_s2_r[7];
    wire p_crs = pin_s2_r[8];
    wire p_txclk_rise = pin_s2_r[9] && !pin_d_r[9];
    wire p_rxclk_rise = pin_s2_r[10] && !pin_d_r[10];
    wire p_rxdv_fall = !pin_s2_r[5] && pin_d_r[5];

    // mode decode
    wire m_int = (port_mode == mpe_pkg::MPE_MODE_INTERNAL); // (R22)
    wire m_mac = (port_mode == mpe_pkg::MPE_MODE_MAC);
    wire m_mii = (port_mode == mpe_pkg::MPE_MODE_MII_PHY);
    wire m_rmii = (port_mode == mpe_pkg::MPE_MODE_RMII_PHY);
    wire m_phy = m_mii || m_rmii; // (R22)
    wire ext_lb = m_phy && external_loopback_bit;
    wire sw_lb = m_phy && switch_loopback_bit && !ext_lb;
    wire iso = m_phy && isolate_bit; // (R13)
    wire ext_ct = m_mii && external_collision_test_bit; // (R16)
    wire sw_ct = m_phy && switch_collision_test_bit; // (R5) (R17)
    wire rate10 = speed_sel_lsb == 1'b0;

    // local clock enable for PHY modes
    logic [7:0] div_r;
    logic [7:0] div_nxt;
    logic [7:0] div_max;
    logic phy_clk_r;
    logic sym_en;
    always_comb
    begin
        if (m_rmii)
            div_max = 8'(`MPE_DIV_RMII - 1); // (R14)
        else if (rate10)
            div_max = 8'(`MPE_DIV_10M - 1);
        else if (turbo_enable)
            div_max = 8'(`MPE_DIV_200M - 1); // (R21)
        else
            div_max = 8'(`MPE_DIV_100M - 1);
        div_nxt = (div_r >= div_max) ? 8'h00 : div_r + 8'h01;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            div_r <= 8'h00;
            phy_clk_r <= 1'b0;
        end
        else
        begin
            div_r <= div_nxt;
            // high for the first half of each period
            phy_clk_r <= (div_nxt <= (div_max >> 1));
        end
    end
    wire rmii_pin_clk = m_rmii && !rmii_clock_out;
    // symbol strobe: local clock, or RMII reference from the pin
    assign sym_en = rmii_pin_clk ? p_txclk_rise : (div_r >= div_max); // (R14)
    wire mac_rx_en = p_rxclk_rise;

    // receive of external transmit in PHY modes (RMII uses two bits)
    wire [3:0] ext_rxd = m_rmii ? {2'h0, p_rxd[1:0]} : p_rxd; // (R12)
    wire ext_txen = !iso && p_rxdv; // (R13)

    // heartbeat timer
    mpe_pkg::mpe_hb_state_t hb_r;
    mpe_pkg::mpe_hb_state_t hb_nxt;
    logic [`MPE_CNT_W-1:0] hb_cnt_r;
    logic [`MPE_CNT_W-1:0] hb_cnt_nxt;
    wire hb_allow = m_mii && rate10 && !full_duplex && !pulse_disable_bit && !iso; // (R1) (R3) (R15)
    always_comb
    begin
        hb_nxt = hb_r;
        hb_cnt_nxt = hb_cnt_r;
        case (hb_r)
            mpe_pkg::MPE_HB_IDLE:
            begin
                if (hb_allow && p_rxdv_fall) // (R1)
                begin
                    hb_nxt = mpe_pkg::MPE_HB_WAIT;
                    hb_cnt_nxt = `MPE_CNT_W'(`MPE_HB_DLY_CYC - 1);
                end
            end
            mpe_pkg::MPE_HB_WAIT:
            begin
                if (!hb_allow)
                    hb_nxt = mpe_pkg::MPE_HB_IDLE;
                else if (hb_cnt_r == '0)
                begin
                    hb_nxt = mpe_pkg::MPE_HB_PULSE; // (R2)
                    hb_cnt_nxt = `MPE_CNT_W'(`MPE_HB_LEN_CYC - 1);
                end
                else
                    hb_cnt_nxt = hb_cnt_r - `MPE_CNT_W'(1);
            end
            mpe_pkg::MPE_HB_PULSE:
            begin
                if (!hb_allow || hb_cnt_r == '0)
                    hb_nxt = mpe_pkg::MPE_HB_IDLE; // (R2)
                else
                    hb_cnt_nxt = hb_cnt_r - `MPE_CNT_W'(1);
            end
            default:
                hb_nxt = mpe_pkg::MPE_HB_IDLE;
        endcase
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hb_r <= mpe_pkg::MPE_HB_IDLE;
            hb_cnt_r <= '0;
        end
        else
        begin
            hb_r <= hb_nxt;
            hb_cnt_r <= hb_cnt_nxt;
        end
    end
    wire hb_pulse = (hb_r == mpe_pkg::MPE_HB_PULSE);
    assign heartbeat_active = hb_pulse && !ext_lb; // (R8)

    // transmit toward pins: registered on symbol strobe, every clock in MAC mode
    logic [3:0] ptx_d_r;
    logic ptx_v_r;
    logic [3:0] ptx_d_nxt;
    logic ptx_v_nxt;
    wire sw_to_pins = m_phy && !ext_lb && !sw_lb && !iso; // (R6) (R10)
    always_comb
    begin
        ptx_d_nxt = ptx_d_r;
        ptx_v_nxt = ptx_v_r;
        if (m_mac)
        begin
            ptx_d_nxt = sw_tx_data; // (R19)
            ptx_v_nxt = sw_tx_en;
        end
        else if (ext_lb && sym_en)
        begin
            ptx_d_nxt = ext_rxd; // (R6)
            ptx_v_nxt = ext_txen;
        end
        else if (sym_en)
        begin
            ptx_d_nxt = sw_to_pins ? sw_tx_data : 4'h0;
            ptx_v_nxt = sw_to_pins && sw_tx_en;
        end
        if (m_rmii)
            ptx_d_nxt[3:2] = 2'h0; // (R12)
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ptx_d_r <= 4'h0;
            ptx_v_r <= 1'b0;
        end
        else
        begin
            ptx_d_r <= ptx_d_nxt;
            ptx_v_r <= ptx_v_nxt;
        end
    end

    // pin collision and carrier in PHY mode
    logic pcol_r;
    logic pcrs_r;
    wire sw_tx_phys = sw_to_pins && sw_tx_en;
    wire pcol_nxt = ext_lb ? (ext_ct && ext_txen) // (R7)
                  : (ext_ct && ext_txen) || heartbeat_active || (!sw_lb && sw_tx_phys && ext_txen && !full_duplex); // (R4) (R8)
    wire pcrs_nxt = ext_lb ? ext_txen : (ext_txen || sw_tx_phys); // (R9)
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pcol_r <= 1'b0;
            pcrs_r <= 1'b0;
        end
        else
        begin
            pcol_r <= pcol_nxt;
            pcrs_r <= pcrs_nxt;
        end
    end

    // pin drivers
    wire drive_data = m_mac || (m_phy && !iso); // (R13)
    assign port1_tx_data_pins = ptx_d_r;
    assign port1_tx_data_oe = drive_data ? (m_rmii ? 4'h3 : 4'hF) : 4'h0; // (R12)
    assign port1_tx_valid_pin = ptx_v_r;
    assign port1_tx_valid_oe = drive_data;
    assign port1_collision_out = pcol_r;
    assign port1_collision_oe = m_mii && !iso; // (R20)
    assign port1_carrier_out = pcrs_r;
    assign port1_carrier_oe = m_mii && !iso; // (R20)
    assign port1_tx_clock_out = phy_clk_r;
    assign port1_tx_clock_oe = (m_mii && !iso) || (m_rmii && rmii_clock_out && !iso); // (R20) (R14)
    assign port1_rx_clock_out = phy_clk_r;
    assign port1_rx_clock_oe = m_mii && !iso; // (R20)

    // receive toward the switch, through the two-entry buffer
    logic [4:0] rx_in;
    logic rx_in_v;
    logic rx_rdy;
    logic [4:0] rx_out;
    logic rx_out_v;
    always_comb
    begin
        rx_in = 5'h00;
        rx_in_v = 1'b0;
        if (m_mac && mac_rx_en && p_rxdv)
        begin
            rx_in = {p_rxer, p_rxd}; // (R19)
            rx_in_v = 1'b1;
        end
        else if (sw_lb && sym_en && sw_tx_en)
        begin
            rx_in = {1'b0, sw_tx_data}; // (R10)
            rx_in_v = 1'b1;
        end
        else if (m_phy && !ext_lb && !sw_lb && sym_en && ext_txen)
        begin
            rx_in = {1'b0, ext_rxd}; // (R6)
            rx_in_v = 1'b1;
        end
    end
    mpe_buf2 u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(rx_in_v),
        .in_ready(rx_rdy),
        .in_data(rx_in),
        .out_valid(rx_out_v),
        .out_ready(sw_rx_ready),
        .out_data(rx_out)
    );

    // switch-side collision and carrier
    wire scol_phy = sw_lb ? (sw_ct && sw_tx_en) // (R11) (R17)
                  : (sw_ct && sw_tx_en) || (!ext_lb && sw_tx_en && ext_txen && !full_duplex); // (R5)
    wire scrs_phy = sw_lb ? sw_tx_en : (ext_lb ? 1'b0 : (ext_txen || sw_tx_en)); // (R11) (R6)
    logic scol_r;
    logic scrs_r;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scol_r <= 1'b0;
            scrs_r <= 1'b0;
        end
        else
        begin
            scol_r <= m_mac ? p_col : scol_phy; // (R19)
            scrs_r <= m_mac ? p_crs : scrs_phy;
        end
    end
    assign iphy_tx_data = m_int ? sw_tx_data : 4'h0; // (R18)
    assign iphy_tx_en = m_int && sw_tx_en;
    assign sw_rx_data = m_int ? iphy_rx_data : rx_out[3:0]; // (R18)
    assign sw_rx_dv = m_int ? iphy_rx_dv : rx_out_v;
    assign sw_rx_er = m_int ? iphy_rx_er : (rx_out_v && rx_out[4]);
    assign sw_col = m_int ? iphy_col : scol_r;
    assign sw_crs = m_int ? iphy_crs : scrs_r;
    // strobe: fabric may present next nibble; stalls while buffer full
    assign sw_tx_strobe = m_int ? 1'b1 : ((m_mac ? mac_rx_en : sym_en) && rx_rdy);
endmodule

// ==== include/mpe_defs.svh ====
// constants for the port data path: clock, timing counts, dividers
// assumes a 250 MHz core clock
`ifndef MPE_DEFS_SVH
`define MPE_DEFS_SVH
`define MPE_CLK_MHZ 250
`define MPE_HB_DLY_MIN_NS 600
`define MPE_HB_DLY_MAX_NS 1600
`define MPE_HB_LEN_MIN_NS 500
`define MPE_HB_LEN_MAX_NS 1500
`define MPE_HB_DLY_NS 1000
`define MPE_HB_LEN_NS 1000
`define MPE_HB_DLY_CYC ((`MPE_HB_DLY_NS * `MPE_CLK_MHZ) / 1000)
`define MPE_HB_LEN_CYC ((`MPE_HB_LEN_NS * `MPE_CLK_MHZ) / 1000)
`define MPE_DIV_100M 10
`define MPE_DIV_200M 5
`define MPE_DIV_10M 100
`define MPE_DIV_RMII 5
`define MPE_CNT_W 10
`endif

// ==== include/mpe_pkg.sv ====
// types for the port data path
// used by the port data path
package mpe_pkg;
    typedef enum logic [3:0] {
        MPE_MODE_INTERNAL = 4'h1,
        MPE_MODE_MAC = 4'h2,
        MPE_MODE_MII_PHY = 4'h4,
        MPE_MODE_RMII_PHY = 4'h8
    } mpe_mode_t;
    typedef enum logic [2:0] {
        MPE_HB_IDLE = 3'h1,
        MPE_HB_WAIT = 3'h2,
        MPE_HB_PULSE = 3'h4
    } mpe_hb_state_t;
endpackage

// ==== design/mpe_buf2.sv ====
// two-entry valid/ready buffer for received nibbles
// assumes both sides on clk
module mpe_buf2 (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [4:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [4:0] out_data
);
    logic [4:0] mem_r [0:1];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rd_ptr_r];
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            cnt_r <= 2'h0;
            mem_r[0] <= 5'h00;
            mem_r[1] <= 5'h00;
        end
        else
        begin
            if (push)
            begin
                mem_r[wr_ptr_r] <= in_data;
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop)
                rd_ptr_r <= ~rd_ptr_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ==== dv/mpe_port_properties.sv ====
// concurrent checks on the port data path
// bound to mpe_port, sees its ports only
module mpe_port_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration
    input wire logic [3:0] port_mode,
    input wire logic isolate_bit,
    input wire logic external_loopback_bit,
    input wire logic switch_loopback_bit,
    input wire logic external_collision_test_bit,
    input wire logic switch_collision_test_bit,
    input wire logic pulse_disable_bit,
    input wire logic full_duplex,
    input wire logic rmii_clock_out,
    // fabric side
    input wire logic sw_tx_en,
    input wire logic sw_tx_strobe,
    input wire logic sw_col,
    // pins
    input wire logic [3:0] port1_tx_data_pins,
    input wire logic [3:0] port1_tx_data_oe,
    input wire logic port1_tx_valid_oe,
    input wire logic port1_rx_valid_pin,
    input wire logic port1_collision_out,
    input wire logic port1_collision_oe,
    input wire logic port1_carrier_oe,
    input wire logic port1_tx_clock_oe,
    input wire logic port1_rx_clock_oe,
    // status
    input wire logic heartbeat_active
);
timeunit 1ns;
timeprecision 1ps;
default clocking @(posedge clk); endclocking
default disable iff (rst);
logic [9:0] idle_r;
logic [9:0] idle_nxt;
logic [9:0] len_r;
logic [9:0] len_nxt;
wire phy_w = port_mode == 4'h4;
wire rmii_w = port_mode == 4'h8;
// cycles since the receive valid pin was last high
assign idle_nxt = port1_rx_valid_pin ? 10'h000 : idle_r + {9'h000, idle_r != 10'h3FF};
assign len_nxt = heartbeat_active ? len_r + 10'h001 : 10'h000;
always_ff @(posedge clk)
begin
    idle_r <= rst ? 10'h3FF : idle_nxt;
    len_r <= rst ? 10'h000 : len_nxt;
end
hb_mode_a: assert property ($rose(heartbeat_active) |-> phy_w && !full_duplex)
    else $error("heartbeat outside half duplex phy mode");
hb_off_a: assert property (pulse_disable_bit || rmii_w || external_loopback_bit |-> !heartbeat_active)
    else $error("heartbeat while suppressed");
hb_delay_a: assert property ($rose(heartbeat_active) |-> idle_r inside {[150:404]})
    else $error("heartbeat start delay out of range");
hb_len_a: assert property ($fell(heartbeat_active) |-> len_r inside {[125:375]})
    else $error("heartbeat length out of range");
ext_col_a: assert property ((phy_w && external_collision_test_bit && !isolate_bit && port1_rx_valid_pin) [*4]
    |-> ##[0:4] port1_collision_out) else $error("no collision in external test");
sw_col_a: assert property ((phy_w || rmii_w) && switch_collision_test_bit && sw_tx_en && sw_tx_strobe
    |-> ##[0:4] sw_col) else $error("no collision in switch test");
iso_a: assert property ((phy_w || rmii_w) && isolate_bit
    |-> port1_tx_data_oe == 4'h0 && !port1_tx_valid_oe && !port1_tx_clock_oe && !port1_collision_oe)
    else $error("isolated pins driven");
mac_oe_a: assert property (port_mode == 4'h2 |-> port1_tx_valid_oe && !port1_collision_oe && !port1_carrier_oe)
    else $error("mac mode pin directions wrong");
phy_clk_a: assert property (phy_w && !isolate_bit
    |-> port1_tx_clock_oe && port1_rx_clock_oe && port1_collision_oe && port1_carrier_oe)
    else $error("phy mode outputs not driven");
rmii_clk_a: assert property (rmii_w && !isolate_bit |-> port1_tx_clock_oe == rmii_clock_out)
    else $error("reference clock direction wrong");
rmii_pair_a: assert property (rmii_w |-> port1_tx_data_pins[3:2] == 2'h0)
    else $error("upper data pins used in reduced mode");
cover property ($rose(heartbeat_active));
cover property (sw_col && rmii_w);
cover property ($fell(port1_rx_valid_pin) && phy_w);
endmodule
bind mpe_port mpe_port_chk chk_u (.*);

// ==== dv/mpe_ext_mac.sv ====
// external MAC model driving the receive pins
// free-running 80 ns link clock, frames on request
module mpe_ext_mac (
    // request from the bench
    input wire logic go,
    input wire logic [5:0] len,
    // pins toward the device
    output logic lclk,
    output logic [3:0] rxd,
    output logic rxdv
);
timeunit 1ns;
timeprecision 1ps;
initial
begin
    lclk = 1'b0;
    forever #40 lclk = ~lclk;
end
initial
begin
    rxd = 4'h0;
    rxdv = 1'b0;
    forever
    begin
        @(posedge go);
        repeat (len)
        begin
            @(negedge lclk);
            rxdv = 1'b1;
            rxd = rxd + 4'h1;
        end
        @(negedge lclk);
        rxdv = 1'b0;
        // released data lines must not keep the last nibble
        rxd = ~rxd;
    end
end
endmodule

// ==== dv/mpe_port_test.sv ====
// self-checking bench for the port data path
// external MAC model on the pins, 250 MHz core clock
module mpe_port_test;
timeunit 1ns;
timeprecision 1ps;
logic clk, rst, iso, elb, slb, ect, sct, pdis, turbo, spd, fdx, rco, stxen, srdy, go, idv, itxen;
logic [3:0] mode, stxd, ird, rxd, srxd, itxd, txoe, ptxd;
logic [5:0] len;
logic rxdv, lclk, srxdv, scol, sstb, hb, colo, coloe, crsoe, tcoe, rcoe, txvoe, ptxv, pcrs, scrs;
int err_count, n_tests, cyc;
mpe_port dut_u (.clk, .rst, .port_mode(mode), .isolate_bit(iso), .external_loopback_bit(elb),
    .switch_loopback_bit(slb), .external_collision_test_bit(ect), .switch_collision_test_bit(sct),
    .pulse_disable_bit(pdis), .turbo_enable(turbo), .speed_sel_lsb(spd), .full_duplex(fdx),
    .rmii_clock_out(rco), .sw_tx_data(stxd), .sw_tx_en(stxen), .sw_rx_data(srxd), .sw_rx_dv(srxdv),
    .sw_rx_er(), .sw_col(scol), .sw_crs(scrs), .sw_tx_strobe(sstb), .sw_rx_ready(srdy),
    .iphy_tx_data(itxd), .iphy_tx_en(itxen), .iphy_rx_data(ird), .iphy_rx_dv(idv), .iphy_rx_er(1'b0),
    .iphy_col(1'b0), .iphy_crs(1'b0), .port1_tx_data_pins(ptxd), .port1_tx_data_oe(txoe),
    .port1_tx_valid_pin(ptxv), .port1_tx_valid_oe(txvoe), .port1_rx_data_pins(rxd), .port1_rx_valid_pin(rxdv),
    .port1_rx_error_pin(1'b0), .port1_collision_in(1'b0), .port1_collision_out(colo),
    .port1_collision_oe(coloe), .port1_carrier_in(rxdv), .port1_carrier_out(pcrs), .port1_carrier_oe(crsoe),
    .port1_tx_clock_in(lclk), .port1_tx_clock_out(), .port1_tx_clock_oe(tcoe), .port1_rx_clock_in(lclk),
    .port1_rx_clock_out(), .port1_rx_clock_oe(rcoe), .heartbeat_active(hb));
mpe_ext_mac mac_u (.go, .len, .lclk, .rxd, .rxdv);
task automatic results;
    $display("compares %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
        err_count++;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
endtask
task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
endtask
task automatic defaults;
    {iso, elb, slb, ect, sct, pdis, turbo, fdx, rco, stxen, idv, go} = 12'h000;
    {spd, srdy} = 2'h3;
    {stxd, ird} = 8'h00;
endtask
task automatic restart(input logic [3:0] m);
    rst = 1'b1;
    mode = m;
    tick(6);
    rst = 1'b0;
    tick(1);
endtask
task automatic start(input logic [5:0] n);
    int i;
    len = n;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    for (i = 0; i < 100 && !rxdv; i++) tick(1);
endtask
task automatic finish;
    int i;
    for (i = 0; i < 600 && rxdv; i++) tick(1);
endtask
task automatic test_hb;
    int d;
    int w;
    defaults();
    spd = 1'b0;
    turbo = 1'b1;
    restart(4'h4);
    start(6'd4);
    finish();
    for (d = 0; d < 600 && !hb; d++) tick(1);
    tick(2);
    check(colo, 1);
    for (w = 2; w < 600 && hb; w++) tick(1);
    check(d >= 150 && d <= 399 && w >= 125 && w <= 375, 1);
    $display("heartbeat test done");
endtask
task automatic test_hb_off;
    logic seen;
    for (int i = 0; i < 4; i++)
    begin
        defaults();
        spd = 1'b0;
        pdis = i == 0;
        elb = i == 2;
        fdx = i == 3;
        restart(i == 1 ? 4'h8 : 4'h4);
        start(6'd4);
        finish();
        seen = 1'b0;
        repeat (500)
        begin
            tick(1);
            seen |= hb | (colo && i == 2);
        end
        check(seen, 0);
    end
    $display("heartbeat suppression test done");
endtask
task automatic test_col;
    for (int j = 0; j < 2; j++)
    begin
        defaults();
        ect = 1'b1;
        elb = j;
        restart(4'h4);
        start(6'd6);
        tick(12);
        check(colo, 1);
        finish();
    end
    for (int j = 0; j < 3; j++)
    begin
        defaults();
        iso = 1'b1;
        sct = j != 2;
        slb = j != 0;
        restart(j == 1 ? 4'h8 : 4'h4);
        stxen = 1'b1;
        stxd = 4'h3;
        tick(40);
        check(scol, j != 2);
    end
    $display("collision test done");
endtask
task automatic test_pins;
    defaults();
    iso = 1'b1;
    restart(4'h4);
    check({txoe, txvoe}, 5'h00);
    restart(4'h2);
    check(txvoe, 1);
    iso = 1'b0;
    rco = 1'b1;
    restart(4'h8);
    check(tcoe, 1);
    rco = 1'b0;
    restart(4'h8);
    check(tcoe, 0);
    restart(4'h4);
    check({tcoe, rcoe, coloe, crsoe}, 4'hF);
    ird = 4'hA;
    idv = 1'b1;
    stxd = 4'h5;
    stxen = 1'b1;
    restart(4'h1);
    check({srxd, srxdv, itxd, itxen}, {4'hA, 1'b1, 4'h5, 1'b1});
    $display("pin direction test done");
endtask
task automatic test_lb;
    logic [3:0] f;
    defaults();
    elb = 1'b1;
    stxen = 1'b1;
    stxd = 4'h5;
    restart(4'h4);
    start(6'd6);
    f = rxd;
    tick(16);
    check({ptxd, ptxv, pcrs, srxdv, scrs}, {f, 4'hC});
    finish();
    tick(20);
    check({ptxv, pcrs}, 2'h0);
    elb = 1'b0;
    slb = 1'b1;
    srdy = 1'b0;
    stxd = 4'h9;
    restart(4'h4);
    start(6'd6);
    tick(16);
    check({srxd, srxdv, ptxv, scrs, scol}, 8'h9A);
    finish();
    $display("loopback test done");
endtask
task automatic test_buf;
    int n;
    logic [3:0] f;
    defaults();
    srdy = 1'b0;
    restart(4'h2);
    start(6'd8);
    f = rxd;
    tick(4);
    check(scrs, 1);
    finish();
    n = 0;
    repeat (40)
    begin
        n += sstb;
        tick(1);
    end
    check(srxdv, 1);
    check(n, 0);
    srdy = 1'b1;
    n = 0;
    for (int k = 0; k < 10; k++)
    begin
        if (k < 2)
            check(srxd, 4'(f + 4'(k)));
        n += srxdv;
        tick(1);
    end
    check(n, 2);
    check(srxdv, 0);
    $display("buffer test done");
endtask
initial
begin
    clk = 1'b0;
    forever #2 clk = ~clk;
end
always @(posedge clk)
begin
    cyc++;
    if (cyc == 40000)
    begin
        err_count++;
        results();
    end
end
initial
begin
    defaults();
    {err_count, n_tests, cyc, len} = 0;
    restart(4'h4);
    test_hb();
    test_hb_off();
    test_col();
    test_pins();
    test_lb();
    test_buf();
    results();
end
endmodule
